//--- rtl/tsrc_pkg.sv
// Purpose: shared constants and types for the soft reset and control block
// Assumes: 10 MHz system clock, byte-wide programming link
// Notes:   link select codes stand for the programming page and the two
//          bus addresses of the remote control module

package tsrc_pkg;

    // ------------------------------------------------------------------
    // programming interface registers
    // ------------------------------------------------------------------
    localparam logic [7:0] REG_SRST   = 8'h40;
    localparam logic [7:0] REG_IPEND  = 8'h3e;
    localparam logic [7:0] REG_IEN    = 8'h3f;
    localparam logic [7:0] RST_VAL    = 8'h00;
    localparam logic [7:0] CTL_WMASK  = 8'h03;
    localparam int         BIT_SRST   = 0;
    localparam int         BIT_GCP    = 1;
    localparam int         BIT_STAB   = 2;
    localparam int         BIT_ALT    = 3;
    localparam int         BIT_ISTAB  = 0;

    // ------------------------------------------------------------------
    // link selects and remote control module
    // ------------------------------------------------------------------
    localparam logic [1:0] SEL_PROG   = 2'h0;
    localparam logic [1:0] SEL_RCM0   = 2'h1;
    localparam logic [1:0] SEL_RCM1   = 2'h2;
    localparam logic [7:0] I2C_RCM0   = 8'hc0;
    localparam logic [7:0] I2C_RCM1   = 8'hc4;
    localparam int         RCM_REGS   = 8;
    localparam logic [3:0] PAD_MOD    = 4'h8;
    localparam logic [7:0] PAD_DATA   = 8'h00;

    // ------------------------------------------------------------------
    // clock monitor timing
    // ------------------------------------------------------------------
    localparam int         CLK_NS     = 100;
    localparam int         MON_TMO_NS = 25500;
    localparam int         MON_WIN_NS = 6400;
    localparam int         MON_TMO    = MON_TMO_NS / CLK_NS;
    localparam int         MON_WIN    = MON_WIN_NS / CLK_NS;
    localparam logic [3:0] MON_HITS   = 4'h4;

    // ------------------------------------------------------------------
    // host controller registers (AHB-Lite byte offsets)
    // ------------------------------------------------------------------
    localparam logic [7:0] A_CTRL     = 8'h00;
    localparam logic [7:0] A_CMD      = 8'h04;
    localparam logic [7:0] A_RDATA    = 8'h08;
    localparam logic [7:0] A_STAT     = 8'h0c;
    localparam logic [7:0] A_ISTAT    = 8'h10;
    localparam logic [7:0] A_ICLR     = 8'h14;
    localparam logic [7:0] A_IEN      = 8'h18;
    localparam int         CTRL_GO    = 0;
    localparam int         CTRL_SEQ   = 1;
    localparam int         CTRL_AUTO  = 2;
    localparam int         CMD_AD     = 8;
    localparam int         CMD_SEL    = 16;
    localparam int         CMD_WE     = 18;
    localparam int         IST_ACC    = 0;
    localparam int         IST_SEQ    = 1;

    typedef enum logic [2:0] {H_IDLE, H_ACC, H_CLRI, H_PAD, H_RD, H_SET, H_CLR} tsrc_hst_e;

endpackage: tsrc_pkg

//--- rtl/tsrc_link_if.sv
// Purpose: byte-wide programming link between host controller and device
// Assumes: request held until acknowledged; acknowledge is one cycle
// Notes:   irq is the device interrupt level

`timescale 1ns/1ps

interface tsrc_link_if;
    logic       req;
    logic       we;
    logic [1:0] sel;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       ack;
    logic [7:0] rdata;
    logic       irq;

    modport dev  (input req, we, sel, addr, wdata, output ack, rdata, irq);
    modport host (output req, we, sel, addr, wdata, input ack, rdata, irq);
endinterface: tsrc_link_if

//--- rtl/tsrc_clk_mon.sv
// Purpose: judges whether the input pixel clock is steady
// Assumes: tick is one pulse per input pixel clock edge, synchronous
// Notes:   period method by default, tick-count window as the alternative

`timescale 1ns/1ps

module tsrc_clk_mon #(
    parameter bit ALT_METHOD = 1'b0
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic tick,
    output logic      stable
);
    import tsrc_pkg::*;

    typedef struct packed {
        logic [7:0] tmr;
        logic [7:0] cnt;
        logic [7:0] ref_v;
        logic [3:0] hits;
        logic       stab;
    } tsrc_mon_s;

    tsrc_mon_s s_ff, nxt_s;
    logic      same;

    always_comb begin
        nxt_s = s_ff;
        same  = 1'b0;
        if (!ALT_METHOD) begin
            if (tick) begin
                same        = (s_ff.tmr == s_ff.ref_v);
                nxt_s.ref_v = s_ff.tmr;
                nxt_s.tmr   = 8'h00;
            end else if (s_ff.tmr == 8'(MON_TMO)) begin
                nxt_s.hits = 4'h0;
                nxt_s.stab = 1'b0;
            end else begin
                nxt_s.tmr = s_ff.tmr + 8'h01;
            end
            if (tick && !same) begin
                nxt_s.hits = 4'h0;
                nxt_s.stab = 1'b0;
            end
        end else begin
            nxt_s.tmr = s_ff.tmr + 8'h01;
            if (tick && s_ff.cnt != 8'hff) begin
                nxt_s.cnt = s_ff.cnt + 8'h01;
            end
            if (s_ff.tmr == 8'(MON_WIN - 1)) begin
                // compare and keep the count before it restarts
                same        = (nxt_s.cnt == s_ff.ref_v) && (nxt_s.cnt != 8'h00);
                nxt_s.ref_v = nxt_s.cnt;
                nxt_s.tmr   = 8'h00;
                nxt_s.cnt   = 8'h00;
                if (!same) begin
                    nxt_s.hits = 4'h0;
                    nxt_s.stab = 1'b0;
                end
            end
        end
        if (same && s_ff.hits != MON_HITS) begin
            nxt_s.hits = s_ff.hits + 4'h1;
        end
        if (same && s_ff.hits == MON_HITS) begin
            nxt_s.stab = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign stable = s_ff.stab;

endmodule: tsrc_clk_mon

//--- rtl/tsrc_dev.sv
// Purpose: device end: soft reset and control register with clock status
// Assumes: link requests held until acknowledged
// Notes:   remote control module registers 0x00..0x07 kept as plain storage

`timescale 1ns/1ps

module tsrc_dev (
    input  wire logic    SYS_CLK,
    input  wire logic    RST,
    tsrc_link_if.dev     LK,
    input  wire logic    PIX_TICK,
    input  wire logic    GCP_SLOT,
    output logic         SECT_RST,
    output logic         GCP_SEND,
    output logic         CLK_STABLE,
    output logic         ALT_STABLE
);
    import tsrc_pkg::*;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic                         srst;
        logic                         gcp;
        logic                         ipend;
        logic                         ien;
        logic                         ack;
        logic [7:0]                   rdata;
        logic                         stab_d;
        logic                         irq;
        logic                         gcp_send;
        logic [RCM_REGS-1:0][7:0]     rcm;
    } tsrc_dev_s;

    tsrc_dev_s s_ff, nxt_s;

    logic       stab;
    logic       alt_stab;
    logic       acc;
    logic       wr;
    logic       rd;
    logic       clr_pend;
    logic       stab_chg;

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    function automatic logic rcm_hit(input logic [1:0] sel, input logic [7:0] addr);
        rcm_hit = (sel == SEL_RCM0 || sel == SEL_RCM1) && (addr[7:3] == 5'h00);
    endfunction: rcm_hit

    function automatic logic prog_hit(input logic [1:0] sel);
        prog_hit = (sel == SEL_PROG);
    endfunction: prog_hit

    // ------------------------------------------------------------------
    // clock monitors
    // ------------------------------------------------------------------
    // period method
    tsrc_clk_mon #(
        .ALT_METHOD (1'b0)
    ) u_mon_main (
        .clk        (SYS_CLK),
        .rst        (RST),
        .tick       (PIX_TICK),
        .stable     (stab)
    );

    tsrc_clk_mon #(
        .ALT_METHOD (1'b1)
    ) u_mon_alt (
        .clk        (SYS_CLK),
        .rst        (RST),
        .tick       (PIX_TICK),
        .stable     (alt_stab)
    );

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        nxt_s    = s_ff;
        clr_pend = 1'b0;

        // one acknowledge per held request
        acc       = LK.req & ~s_ff.ack;
        wr        = acc & LK.we;
        rd        = acc & ~LK.we;
        nxt_s.ack = acc;

        // register writes
        if (wr && prog_hit(LK.sel)) begin
            unique case (LK.addr)
                REG_SRST: begin
                    nxt_s.srst = LK.wdata[BIT_SRST];
                    nxt_s.gcp  = LK.wdata[BIT_GCP];
                end
                REG_IPEND: begin
                    clr_pend = LK.wdata[BIT_ISTAB];
                end
                REG_IEN: begin
                    nxt_s.ien = LK.wdata[BIT_ISTAB];
                end
                default: begin
                    clr_pend = 1'b0;
                end
            endcase
        end
        if (wr && rcm_hit(LK.sel, LK.addr)) begin
            nxt_s.rcm[LK.addr[2:0]] = LK.wdata;
        end

        // register reads
        if (rd) begin
            nxt_s.rdata = RST_VAL;
            if (prog_hit(LK.sel)) begin
                unique case (LK.addr)
                    REG_SRST: begin
                        nxt_s.rdata[BIT_SRST] = s_ff.srst;
                        nxt_s.rdata[BIT_GCP]  = s_ff.gcp;
                        nxt_s.rdata[BIT_STAB] = stab;
                        nxt_s.rdata[BIT_ALT]  = alt_stab;
                    end
                    REG_IPEND: begin
                        nxt_s.rdata[BIT_ISTAB] = s_ff.ipend;
                    end
                    REG_IEN: begin
                        nxt_s.rdata[BIT_ISTAB] = s_ff.ien;
                    end
                    default: begin
                        nxt_s.rdata = RST_VAL;
                    end
                endcase
            end else if (rcm_hit(LK.sel, LK.addr)) begin
                nxt_s.rdata = s_ff.rcm[LK.addr[2:0]];
            end
        end

        stab_chg     = (stab != s_ff.stab_d);
        nxt_s.stab_d = stab;
        if (clr_pend || s_ff.srst) begin
            nxt_s.ipend = 1'b0;
        end
        if (stab_chg) begin
            nxt_s.ipend = 1'b1;
        end
        nxt_s.irq = nxt_s.ipend & nxt_s.ien;

        nxt_s.gcp_send = GCP_SLOT & s_ff.gcp & ~s_ff.srst;
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign LK.ack   = s_ff.ack;
    assign LK.rdata = s_ff.rdata;
    assign LK.irq   = s_ff.irq;

    assign SECT_RST   = s_ff.srst;
    assign GCP_SEND   = s_ff.gcp_send;
    assign CLK_STABLE = stab;
    assign ALT_STABLE = alt_stab;

endmodule: tsrc_dev

//--- rtl/tsrc_host.sv
// Purpose: host controller end: AHB-Lite orders, link accesses, reset sequence
// Assumes: zero-wait AHB-Lite slave, word transfers only
// Notes:   reset sequence pads remote writes, then sets and clears reset bit

`timescale 1ns/1ps

module tsrc_host (
    input  wire logic        SYS_CLK,
    input  wire logic        RST,
    tsrc_link_if.host        LK,
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic             HREADYOUT,
    output logic             HRESP,
    output logic [31:0]      HRDATA,
    output logic             IRQ
);
    import tsrc_pkg::*;

    typedef struct packed {
        tsrc_hst_e   st;
        logic        req;
        logic        ap_valid;
        logic        ap_wr;
        logic [7:0]  ap_addr;
        logic [31:0] hrdata;
        logic [18:0] cmd;
        logic        auto_rst;
        logic [7:0]  rdat;
        logic [7:0]  r40;
        logic [2:0]  wcnt;
        logic [3:0]  pad;
        logic [1:0]  ist;
        logic [1:0]  ien;
        logic        irq;
    } tsrc_host_s;

    tsrc_host_s s_ff, nxt_s;
    logic       go_acc;
    logic       go_seq;
    logic       l_we;
    logic [1:0] l_sel;
    logic [7:0] l_addr;
    logic [7:0] l_wdata;

    // ------------------------------------------------------------------
    // link request fields
    // ------------------------------------------------------------------
    always_comb begin
        l_we    = 1'b1;
        l_sel   = SEL_PROG;
        l_addr  = REG_SRST;
        l_wdata = RST_VAL;
        unique case (s_ff.st)
            H_ACC: begin
                l_we    = s_ff.cmd[CMD_WE];
                l_sel   = s_ff.cmd[CMD_SEL +: 2];
                l_addr  = s_ff.cmd[CMD_AD +: 8];
                l_wdata = s_ff.cmd[7:0];
            end
            H_CLRI: begin
                l_addr  = REG_IPEND;
                l_wdata = 8'h01;
            end
            H_PAD: begin
                l_sel   = SEL_RCM0;
                l_addr  = {5'h00, 3'(s_ff.pad - 4'h1)};
                l_wdata = PAD_DATA;
            end
            H_RD: begin
                l_we = 1'b0;
            end
            H_SET: begin
                l_wdata = (s_ff.r40 & CTL_WMASK) | 8'h01;
            end
            H_CLR: begin
                l_wdata = s_ff.r40 & CTL_WMASK & 8'hfe;
            end
            H_IDLE: begin
                l_we = 1'b0;
            end
            default: begin
                l_we = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        nxt_s  = s_ff;
        go_acc = 1'b0;
        go_seq = 1'b0;

        // bus data phase writes
        if (s_ff.ap_valid && s_ff.ap_wr) begin
            unique case (s_ff.ap_addr)
                A_CTRL: begin
                    go_acc         = HWDATA[CTRL_GO];
                    go_seq         = HWDATA[CTRL_SEQ];
                    nxt_s.auto_rst = HWDATA[CTRL_AUTO];
                end
                A_CMD:   nxt_s.cmd = HWDATA[18:0];
                A_ICLR:  nxt_s.ist = s_ff.ist & ~HWDATA[1:0];
                A_IEN:   nxt_s.ien = HWDATA[1:0];
                default: nxt_s.cmd = s_ff.cmd;
            endcase
        end

        // bus address phase; read data captured now
        nxt_s.ap_valid = HSEL & HTRANS[1] & HREADY;
        nxt_s.ap_wr    = HWRITE;
        nxt_s.ap_addr  = HADDR[7:0];
        nxt_s.hrdata   = 32'h0000_0000;
        if (nxt_s.ap_valid && !HWRITE) begin
            unique case (HADDR[7:0])
                A_CTRL:  nxt_s.hrdata = {29'h0, s_ff.auto_rst, 2'h0};
                A_CMD:   nxt_s.hrdata = {13'h0, s_ff.cmd};
                A_RDATA: nxt_s.hrdata = {24'h0, s_ff.rdat};
                A_STAT:  nxt_s.hrdata = {26'h0, s_ff.auto_rst, LK.irq, s_ff.wcnt,
                                         s_ff.st != H_IDLE};
                A_ISTAT: nxt_s.hrdata = {30'h0, s_ff.ist};
                A_IEN:   nxt_s.hrdata = {30'h0, s_ff.ien};
                default: nxt_s.hrdata = 32'h0000_0000;
            endcase
        end

        // job start
        if (s_ff.st == H_IDLE) begin
            if (go_seq) begin
                nxt_s.st  = H_PAD;
                nxt_s.pad = PAD_MOD - {1'b0, s_ff.wcnt};
            end else if (go_acc) begin
                nxt_s.st = H_ACC;
            end else if (s_ff.auto_rst && LK.irq) begin
                nxt_s.st = H_CLRI;
            end
        end

        // link handshake
        if (s_ff.req && LK.ack) begin
            nxt_s.req = 1'b0;
            if (l_we && l_sel != SEL_PROG) begin
                nxt_s.wcnt = s_ff.wcnt + 3'h1;
            end
            unique case (s_ff.st)
                H_ACC: begin
                    if (!l_we) begin
                        nxt_s.rdat = LK.rdata;
                    end
                    nxt_s.ist[IST_ACC] = 1'b1;
                    nxt_s.st           = H_IDLE;
                end
                H_CLRI: begin
                    nxt_s.st  = H_PAD;
                    nxt_s.pad = PAD_MOD - {1'b0, s_ff.wcnt};
                end
                H_PAD: begin
                    // N = 8 - (W mod 8)
                    nxt_s.pad = s_ff.pad - 4'h1;
                    if (s_ff.pad == 4'h1) begin
                        nxt_s.st = H_RD;
                    end
                end
                H_RD: begin
                    nxt_s.r40 = LK.rdata;
                    nxt_s.st  = H_SET;
                end
                H_SET:   nxt_s.st = H_CLR;
                H_CLR: begin
                    nxt_s.ist[IST_SEQ] = 1'b1;
                    nxt_s.st           = H_IDLE;
                end
                H_IDLE:  nxt_s.st = H_IDLE;
                default: nxt_s.st = H_IDLE;
            endcase
        end else if (!s_ff.req && !LK.ack && s_ff.st != H_IDLE) begin
            nxt_s.req = 1'b1;
        end

        nxt_s.irq = |(nxt_s.ist & nxt_s.ien);
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign LK.req    = s_ff.req;
    assign LK.we     = l_we;
    assign LK.sel    = l_sel;
    assign LK.addr   = l_addr;
    assign LK.wdata  = l_wdata;
    assign HREADYOUT = 1'b1;
    assign HRESP     = 1'b0;
    assign HRDATA    = s_ff.hrdata;
    assign IRQ       = s_ff.irq;

endmodule: tsrc_host

//--- testbench/tsrc_link_monitor.sv
// Purpose: checks the link between the host and device ends
// Assumes: one clock, reset active high
// Notes:   sees the interface signals only
`timescale 1ns/1ps

module tsrc_link_monitor (
    input wire logic       SYS_CLK,
    input wire logic       RST,
    input wire logic       req,
    input wire logic       we,
    input wire logic [1:0] sel,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       ack,
    input wire logic [7:0] rdata,
    input wire logic       irq
);
    import tsrc_pkg::*;
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    wire prog_wr = req && we && sel == SEL_PROG;
    // ----
    // handshake
    // ----
    AST_ACK_ONE: assert property (ack |=> !ack)
        else $error("ack longer than one cycle");
    AST_ACK_TIME: assert property ($rose(req) |-> !ack ##1 ack)
        else $error("ack not one cycle after request");
    AST_ACK_CAUSE: assert property (ack |-> req && $past(req))
        else $error("ack without request");
    AST_REQ_HOLD: assert property (req && !ack |=> req && $stable({we, sel, addr, wdata}))
        else $error("request changed before ack");
    AST_REQ_DROP: assert property (ack |=> !req)
        else $error("request kept after ack");
    // ----
    // device rules
    // ----
    AST_PAD_RANGE: assert property (req && we && sel != SEL_PROG |-> addr < RCM_REGS)
        else $error("remote write outside pad range");
    AST_SRST_CLR: assert property (
        ack && $past(prog_wr && addr == REG_SRST && wdata[BIT_SRST])
        |-> ##[1:40] (prog_wr && addr == REG_SRST && !wdata[BIT_SRST]))
        else $error("reset bit not cleared after set");
    AST_IEN_OFF: assert property (
        prog_wr && !ack && addr == REG_IEN && !wdata[BIT_ISTAB] |-> ##[1:3] !irq)
        else $error("irq high with enable cleared");
    cover property (ack && we && sel != SEL_PROG);
    cover property (prog_wr && addr == REG_SRST && wdata[BIT_SRST]);
    cover property ($rose(irq));
endmodule: tsrc_link_monitor

//--- testbench/tsrc_tb.sv
// Purpose: self-checking bench joining host and device ends
// Assumes: zero-wait bus slave, pixel tick every four cycles
// Notes:   scenarios run in order; state carries over
`timescale 1ns/1ps

module tsrc_tb;
    import tsrc_pkg::*;
    logic        SYS_CLK  = 1'b0;
    logic        RST      = 1'b1;
    logic        PIX_TICK = 1'b0;
    logic        GCP_SLOT = 1'b0;
    logic        HSEL     = 1'b0;
    logic [31:0] HADDR    = '0;
    logic [1:0]  HTRANS   = '0;
    logic        HWRITE   = 1'b0;
    logic [31:0] HWDATA   = '0;
    logic [31:0] HRDATA;
    logic        HREADYOUT, HRESP, IRQ, SECT_RST, GCP_SEND, CLK_STABLE, ALT_STABLE;
    logic        pix_on   = 1'b0;
    logic [1:0]  tdiv     = '0;
    int          fail_count = 0;
    int          cmp_count  = 0;
    tsrc_link_if lk ();
    always #50 SYS_CLK = ~SYS_CLK;
    always @(posedge SYS_CLK) begin
        tdiv     <= tdiv + 2'h1;
        PIX_TICK <= pix_on && tdiv == 2'h0;
    end
    tsrc_dev i_tsrc_dev (.SYS_CLK(SYS_CLK), .RST(RST), .LK(lk), .PIX_TICK(PIX_TICK),
        .GCP_SLOT(GCP_SLOT), .SECT_RST(SECT_RST), .GCP_SEND(GCP_SEND),
        .CLK_STABLE(CLK_STABLE), .ALT_STABLE(ALT_STABLE));
    tsrc_host i_tsrc_host (.SYS_CLK(SYS_CLK), .RST(RST), .LK(lk), .HSEL(HSEL),
        .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA),
        .HREADY(HREADYOUT), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .HRDATA(HRDATA),
        .IRQ(IRQ));
    tsrc_link_monitor i_tsrc_link_monitor (.SYS_CLK(SYS_CLK), .RST(RST), .req(lk.req),
        .we(lk.we), .sel(lk.sel), .addr(lk.addr), .wdata(lk.wdata), .ack(lk.ack),
        .rdata(lk.rdata), .irq(lk.irq));
    // ----
    // helpers
    // ----
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask: chk
    task automatic finish_test();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask: finish_test
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        HSEL   <= 1'b1;
        HADDR  <= {24'h0, a};
        HTRANS <= 2'b10;
        HWRITE <= w;
        do @(posedge SYS_CLK); while (HREADYOUT !== 1'b1);
        HSEL   <= 1'b0;
        HTRANS <= 2'b00;
        HWDATA <= d;
        do @(posedge SYS_CLK); while (HREADYOUT !== 1'b1);
        r = HRDATA;
    endtask: ahb
    task automatic wait_idle();
        logic [31:0] r;
        repeat (2) @(posedge SYS_CLK);
        repeat (60) begin
            ahb(1'b0, A_STAT, 32'h0, r);
            if (r[0] === 1'b0)
                break;
        end
        chk(r[0], 0);
    endtask: wait_idle
    // one link access ordered through the host, answer from RDATA
    task automatic acc(input logic w, input logic [1:0] s, input logic [7:0] a,
                       input logic [7:0] d, output logic [31:0] r);
        ahb(1'b1, A_CMD, {13'h0, w, s, a, d}, r);
        ahb(1'b1, A_CTRL, 32'h1, r);
        wait_idle();
        ahb(1'b0, A_RDATA, 32'h0, r);
    endtask: acc
    // ----
    // scenarios
    // ----
    task automatic t_reset();
        logic [31:0] r;
        ahb(1'b0, A_STAT, 32'h0, r);
        chk(r, 32'h0);
        chk(HRESP, 0);
        ahb(1'b1, 8'h1c, 32'hffffffff, r);
        ahb(1'b0, 8'h1c, 32'h0, r);
        chk(r, 32'h0);
        acc(1'b0, SEL_PROG, REG_SRST, 8'h00, r);
        chk(r, 32'h0);
        acc(1'b0, SEL_RCM0, 8'h09, 8'h00, r);
        chk(r, 32'h0);
        $display("test reset done");
    endtask: t_reset
    task automatic t_clock();
        logic [31:0] r;
        acc(1'b1, SEL_PROG, REG_IEN, 8'h01, r);
        pix_on <= 1'b1;
        repeat (800) @(posedge SYS_CLK);
        chk(CLK_STABLE, 1);
        chk(ALT_STABLE, 1);
        acc(1'b0, SEL_PROG, REG_SRST, 8'h00, r);
        chk(r, 32'h0c);
        ahb(1'b0, A_STAT, 32'h0, r);
        chk(r[4], 1);
        acc(1'b1, SEL_PROG, REG_IPEND, 8'h00, r);
        ahb(1'b0, A_STAT, 32'h0, r);
        chk(r[4], 1);
        acc(1'b1, SEL_PROG, REG_IPEND, 8'h01, r);
        ahb(1'b0, A_STAT, 32'h0, r);
        chk(r[4], 0);
        pix_on <= 1'b0;
        repeat (400) @(posedge SYS_CLK);
        chk(CLK_STABLE, 0);
        ahb(1'b0, A_STAT, 32'h0, r);
        chk(r[4], 1);
        acc(1'b1, SEL_PROG, REG_IEN, 8'h00, r);
        ahb(1'b0, A_STAT, 32'h0, r);
        chk(r[4], 0);
        $display("test clock done");
    endtask: t_clock
    task automatic t_gcp();
        logic [31:0] r;
        GCP_SLOT <= 1'b1;
        acc(1'b1, SEL_PROG, REG_SRST, 8'h00, r);
        chk(GCP_SEND, 0);
        acc(1'b1, SEL_PROG, REG_SRST, 8'h02, r);
        chk(GCP_SEND, 1);
        acc(1'b1, SEL_PROG, REG_SRST, 8'h03, r);
        chk(SECT_RST, 1);
        chk(GCP_SEND, 0);
        acc(1'b1, SEL_PROG, REG_SRST, 8'h02, r);
        chk(SECT_RST, 0);
        $display("test packet done");
    endtask: t_gcp
    task automatic t_seq();
        logic [31:0] r;
        logic        seen;
        seen = 1'b0;
        acc(1'b1, SEL_RCM0, 8'h05, 8'h5a, r);
        acc(1'b1, SEL_RCM1, 8'h07, 8'ha5, r);
        acc(1'b1, SEL_RCM0, 8'h04, 8'h3c, r);
        ahb(1'b0, A_STAT, 32'h0, r);
        chk(r[3:1], 3);
        chk(IRQ, 0);
        ahb(1'b1, A_IEN, 32'h2, r);
        ahb(1'b1, A_CTRL, 32'h2, r);
        repeat (300) begin
            @(posedge SYS_CLK);
            if (SECT_RST === 1'b1)
                seen = 1'b1;
            if (IRQ === 1'b1)
                break;
        end
        chk(seen, 1);
        chk(IRQ, 1);
        chk(SECT_RST, 0);
        ahb(1'b0, A_ISTAT, 32'h0, r);
        chk(r[1], 1);
        ahb(1'b0, A_STAT, 32'h0, r);
        chk(r[3:1], 0);
        acc(1'b0, SEL_PROG, REG_SRST, 8'h00, r);
        chk(r[1:0], 2'b10);
        acc(1'b0, SEL_RCM0, 8'h05, 8'h00, r);
        chk(r, 32'h5a);
        acc(1'b0, SEL_RCM0, 8'h04, 8'h00, r);
        chk(r, 32'h0);
        ahb(1'b1, A_ICLR, 32'h2, r);
        repeat (2) @(posedge SYS_CLK);
        chk(IRQ, 0);
        $display("test sequence done");
    endtask: t_seq
    task automatic t_auto();
        logic [31:0] r;
        acc(1'b1, SEL_PROG, REG_IEN, 8'h01, r);
        ahb(1'b1, A_CTRL, 32'h4, r);
        pix_on <= 1'b1;
        repeat (300) begin
            @(posedge SYS_CLK);
            if (IRQ === 1'b1)
                break;
        end
        chk(IRQ, 1);
        chk(CLK_STABLE, 1);
        ahb(1'b0, A_STAT, 32'h0, r);
        chk(r[5:4], 2'b10);
        repeat (600) @(posedge SYS_CLK);
        chk(ALT_STABLE, 1);
        ahb(1'b0, A_STAT, 32'h0, r);
        chk(r[5:0], 6'h20);
        ahb(1'b1, A_CTRL, 32'h0, r);
        ahb(1'b1, A_ICLR, 32'h2, r);
        $display("test auto reset done");
    endtask: t_auto
    initial begin
        repeat (12) @(posedge SYS_CLK);
        RST <= 1'b0;
        @(posedge SYS_CLK);
        t_reset();
        t_clock();
        t_gcp();
        t_seq();
        t_auto();
        finish_test();
    end
    initial begin
        repeat (20000) @(posedge SYS_CLK);
        fail_count++;
        $display("ERROR %0t watchdog expired", $time);
        finish_test();
    end
endmodule: tsrc_tb
